/* rtl/sst_seq.sv */
`include "sst_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sst_seq #(
  parameter int CYC_PER_TICK = `SST_CYC_PER_TICK,
  parameter int TMO_W        = 16,
  parameter int TR_W         = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire sst_pkg::sst_sens_t sensor_type,
  input  wire logic              light_curtain_input_b,
  input  wire logic              pressure_edge_input_b,
  input  wire logic              light_barrier_input_b,
  input  wire logic              normal_mode,
  input  wire logic              door_at_open_end,
  input  wire logic              door_move_cmd,
  input  wire logic              constant_speed,
  input  wire logic [TMO_W-1:0]  test_timeout_parameter,
  input  wire logic [TR_W-1:0]   sensor_reaction_ms,
  input  wire logic [TR_W-1:0]   discrepancy_min_ms,
  input  wire logic              fault_ack,
  output logic                   sensor_test_stimulus,
  output logic                   test_busy,
  output logic                   fault_active,
  output logic [7:0]             fault_code,
  output logic                   current_reduce,
  output logic                   drive_reverse
);
  import sst_pkg::*;

  // two spare bits so twice the timeout never wraps
  localparam int EW = TMO_W + 2;
  localparam logic [7:0] REACT_TICKS = 8'(`SST_REACT_MS);

  // ms enable shared with the divider
  sst_tick_if tk ();

  sst_tick_div #(.CYC_PER_TICK(CYC_PER_TICK)) u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .tk    (tk)
  );

  sst_state_t     state_reg, state_next;
  logic [EW-1:0]  elapsed_reg;
  logic [EW-1:0]  phase_reg;
  logic           open_end_reg;
  logic           stim_reg;
  logic           fault_reg;
  logic [7:0]     code_reg;
  logic [7:0]     react_reg;
  logic           reduce_reg;
  logic           reverse_reg;
  logic           busy_reg;

  // configured sensor decode and its response level (inputs active low)
  wire tested_type = (sensor_type == SST_SENS_CURTAIN) || (sensor_type == SST_SENS_EDGE);
  wire resp_active = (sensor_type == SST_SENS_CURTAIN) ? !light_curtain_input_b
                                                       : !pressure_edge_input_b;
  // tested sensor (curtain or edge) and barrier ORed; barrier also counts with no tested sensor
  wire sens_active = (tested_type && resp_active) || !light_barrier_input_b;

  // test timing targets in ms ticks
  wire [EW-1:0] half_min  = EW'(sensor_reaction_ms) + EW'(discrepancy_min_ms);
  wire [EW-1:0] limit_ms  = EW'(test_timeout_parameter) * EW'(`SST_TEST_FACTOR);
  wire          busy      = (state_reg != SST_IDLE);
  wire          timed_out = busy && (elapsed_reg >= limit_ms);
  wire          start     = open_end_reg && !door_at_open_end && door_move_cmd
                            && normal_mode && tested_type && !busy;
  wire          half_done = (phase_reg > half_min); // one spare tick covers tick skew
  wire          ms_run    = busy && tk.tick;
  wire          pass      = (state_reg == SST_RELEASE) && !resp_active && half_done
                            && !timed_out;

  // sequence: stimulus on until sensor answers, then off until it recovers
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SST_IDLE:    if (start) state_next = SST_DRIVE;
      SST_DRIVE:   begin
        if (timed_out) state_next = SST_IDLE;
        else if (resp_active && half_done) state_next = SST_RELEASE;
      end
      SST_RELEASE: begin
        if (timed_out || pass) state_next = SST_IDLE;
      end
      default:     state_next = SST_IDLE;
    endcase
  end

  wire phase_clr = (state_next != state_reg);

  // one ms step of a test counter; holds between enables
  function automatic logic [EW-1:0] ms_step(input logic [EW-1:0] cnt, input logic run);
    return run ? cnt + EW'(1) : cnt;
  endfunction

  // state and test counters; busy flop mirrors the state so the output leaves a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= SST_IDLE;
      busy_reg     <= 1'b0;
      elapsed_reg  <= '0;
      phase_reg    <= '0;
      open_end_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      busy_reg     <= (state_next != SST_IDLE);
      open_end_reg <= door_at_open_end;
      elapsed_reg  <= start ? '0 : ms_step(elapsed_reg, ms_run);
      phase_reg    <= phase_clr ? '0 : ms_step(phase_reg, ms_run);
    end
  end

  // stimulus follows the drive phase; dropped at once if the type is no longer curtain or edge
  wire stim_next  = (state_next == SST_DRIVE) && tested_type;
  // set wins over acknowledge so a fresh failure is never lost
  wire fault_next = timed_out || (fault_reg && !fault_ack);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stim_reg  <= 1'b0;
      fault_reg <= 1'b0;
      code_reg  <= `SST_FAULT_NONE;
    end else begin
      stim_reg  <= stim_next;
      fault_reg <= fault_next;
      code_reg  <= fault_next ? `SST_FAULT_TEST : `SST_FAULT_NONE;
    end
  end

  // reaction timer; sensor answers to the own stimulus are not obstacles
  wire react_arm  = sens_active && !busy;
  wire react_hit  = react_arm && tk.tick && (react_reg == REACT_TICKS - 8'(1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      react_reg   <= '0;
      reduce_reg  <= 1'b0;
      reverse_reg <= 1'b0;
    end else begin
      if (!react_arm) react_reg <= '0;
      else if (tk.tick && react_reg != REACT_TICKS) react_reg <= react_reg + 8'(1);
      reduce_reg  <= react_arm && (react_hit || reduce_reg);
      reverse_reg <= react_hit && constant_speed;
    end
  end

  // outputs straight from their flops
  assign sensor_test_stimulus = stim_reg;
  assign test_busy            = busy_reg;
  assign fault_active         = fault_reg;
  assign fault_code           = code_reg;
  assign current_reduce       = reduce_reg;
  assign drive_reverse        = reverse_reg;

  // checks on the test sequence and the reaction timing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  localparam longint REACT_MIN_CYC = longint'(`SST_REACT_MIN_MS) * CYC_PER_TICK;
  localparam longint REACT_MAX_CYC = longint'(`SST_REACT_MAX_MS) * CYC_PER_TICK;
  longint act_cyc;
  longint test_cyc;

  // cycles since obstacle seen, for the reaction window check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) act_cyc <= '0;
    else act_cyc <= react_arm ? act_cyc + longint'(1) : '0;
  end

  // cycles since the test start, for the minimum duration check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) test_cyc <= '0;
    else test_cyc <= start ? '0 : (busy ? test_cyc + longint'(1) : test_cyc);
  end

  sequence s_leave_open;
    open_end_reg && !door_at_open_end && door_move_cmd && normal_mode && tested_type && !busy;
  endsequence
  sequence s_stim_up;
    state_reg == SST_DRIVE ##0 stim_reg;
  endsequence

  a_test_start_stim : assert property (
    s_leave_open |=> (state_reg == SST_DRIVE) ##1 s_stim_up)
    else $error("test start did not raise stimulus");
  a_stim_needs_cfg : assert property (stim_reg |-> $past(tested_type))
    else $error("stimulus driven without tested sensor type");
  a_stim_in_drive : assert property (
    stim_reg |-> state_reg == SST_DRIVE)
    else $error("stimulus driven outside the drive phase");
  a_min_duration : assert property (
    pass |-> test_cyc + 1 >= longint'(half_min) * 2 * CYC_PER_TICK)
    else $error("test passed sooner than minimum duration");
  a_timeout_fault : assert property (
    timed_out |=> fault_reg && code_reg == `SST_FAULT_TEST)
    else $error("timeout did not raise fault");
  a_fault_held : assert property (
    fault_reg && !fault_ack |=> fault_reg ##0 code_reg == `SST_FAULT_TEST)
    else $error("fault dropped without acknowledge");
  a_react_window : assert property (
    $rose(reduce_reg) |-> ($past(act_cyc) + 1 >= REACT_MIN_CYC)
                          && ($past(act_cyc) + 1 <= REACT_MAX_CYC))
    else $error("reaction outside allowed window");
  a_reduce_drop : assert property (
    !react_arm |=> !reduce_reg)
    else $error("current reduction held without obstacle");
  a_reverse_cause : assert property (
    reverse_reg |-> $past(constant_speed) && $rose(reduce_reg))
    else $error("reverse without constant speed activation");
  a_barrier_or : assert property (
    !light_barrier_input_b && !busy && tk.tick |=> react_reg != 8'h00)
    else $error("light barrier not combined into reaction");
endmodule
`default_nettype wire

/* rtl/sst_cfg.svh */
`ifndef SST_CFG_SVH
`define SST_CFG_SVH

// clock rate and base tick of all sequencer timing
`define SST_CLK_MHZ        100
`define SST_TICK_US        1000
`define SST_CYC_PER_TICK   (`SST_TICK_US * `SST_CLK_MHZ)

// reaction window from sensor activation to current reduction, in ms
`define SST_REACT_MIN_MS   70
`define SST_REACT_MAX_MS   90
`define SST_REACT_MS       ((`SST_REACT_MIN_MS + `SST_REACT_MAX_MS) / 2)

// test limit factor and fault number raised on a failed test
`define SST_TEST_FACTOR    2
`define SST_FAULT_TEST     8'h08
`define SST_FAULT_NONE     8'h00

// sensor type codes on the configuration input
`define SST_TYPE_NONE      2'h0
`define SST_TYPE_CURTAIN   2'h1
`define SST_TYPE_EDGE      2'h2

`endif

/* rtl/sst_pkg.sv */
package sst_pkg;
  typedef enum logic [1:0] {
    SST_SENS_NONE    = 2'b00,
    SST_SENS_CURTAIN = 2'b01,
    SST_SENS_EDGE    = 2'b10,
    SST_SENS_RSVD    = 2'b11
  } sst_sens_t;

  typedef enum logic [1:0] {
    SST_IDLE    = 2'b00,
    SST_DRIVE   = 2'b01,
    SST_RELEASE = 2'b10
  } sst_state_t;
endpackage

/* rtl/sst_tick_if.sv */
`timescale 1ns/100ps
`default_nettype none
// millisecond enable shared between divider and sequencer
interface sst_tick_if;
  logic tick;
  modport gen (output tick);
  modport use_side (input tick);
endinterface
`default_nettype wire

/* rtl/sst_tick_div.sv */
`include "sst_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sst_tick_div #(
  parameter int CYC_PER_TICK = `SST_CYC_PER_TICK
) (
  input  wire logic clk,
  input  wire logic rst_b,
  sst_tick_if.gen   tk
);
  localparam int CW = $clog2(CYC_PER_TICK);

  logic [CW-1:0] cnt_reg;
  logic          tick_reg;
  wire           wrap = (cnt_reg == CW'(CYC_PER_TICK - 1));

  // free-running divider, one-cycle enable at wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= wrap ? '0 : cnt_reg + CW'(1);
      tick_reg <= wrap;
    end
  end

  // enable leaves straight from its flop
  assign tk.tick = tick_reg;

  a_tick_spacing : assert property (@(posedge clk) disable iff (!rst_b)
    tick_reg |=> !tick_reg)
    else $error("tick enable lasted more than one cycle");
endmodule
`default_nettype wire

/* tb/sst_sens_model.sv */
`timescale 1ns/100ps
`default_nettype none
// behavioural safety sensor, follows the test stimulus after a short delay
module sst_sens_model #(
  parameter int DLY = 3
) (
  input  wire logic clk,
  input  wire logic stim,
  input  wire logic dead,
  input  wire logic obstacle,
  output logic      sens_b
);
  logic [DLY-1:0] pipe = '0;
  // delay line of the stimulus; a dead sensor never answers
  always @(posedge clk) begin
    pipe <= {pipe[DLY-2:0], stim};
  end
  // active low: an answered stimulus or an obstacle pulls the line low
  assign sens_b = ~((pipe[DLY-1] & ~dead) | obstacle);
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import sst_pkg::*;
  localparam int CPT = 10; // 1 ms = 10 cycles in simulation
  logic        clk = 0, rst_b = 0, normal_mode = 0, door_at_open_end = 0;
  logic        door_move_cmd = 0, constant_speed = 0, fault_ack = 0;
  logic        light_barrier_input_b = 1, dead = 0, obstacle = 0;
  sst_sens_t   sensor_type = SST_SENS_NONE;
  logic [15:0] tmo = 16'h0064;
  logic [7:0]  tr = 8'h02;
  logic [7:0]  td = 8'h01;
  logic        stim, busy, flt, cur_red, rev, sens_b;
  logic [7:0]  code;
  int          fail_count = 0;
  int          total_checks = 0;
  int          n;
  always #5 clk = ~clk;
  sst_seq #(.CYC_PER_TICK(CPT)) dut (
    .clk(clk), .rst_b(rst_b), .sensor_type(sensor_type),
    .light_curtain_input_b(sens_b), .pressure_edge_input_b(sens_b),
    .light_barrier_input_b(light_barrier_input_b), .normal_mode(normal_mode),
    .door_at_open_end(door_at_open_end), .door_move_cmd(door_move_cmd),
    .constant_speed(constant_speed), .test_timeout_parameter(tmo),
    .sensor_reaction_ms(tr), .discrepancy_min_ms(td), .fault_ack(fault_ack),
    .sensor_test_stimulus(stim), .test_busy(busy), .fault_active(flt),
    .fault_code(code), .current_reduce(cur_red), .drive_reverse(rev));
  sst_sens_model #(.DLY(3)) partner (
    .clk(clk), .stim(stim), .dead(dead), .obstacle(obstacle), .sens_b(sens_b));
  // bounded wait at falling edges, n holds the cycles spent
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // door leaves the opened end stop under a door command
  task automatic depart();
    door_at_open_end = 1;
    door_move_cmd = 1;
    repeat (3) @(negedge clk);
    door_at_open_end = 0;
    @(negedge clk);
  endtask
  task automatic t_pass();
    sensor_type = SST_SENS_CURTAIN;
    depart();
    wait_for(busy, 1'b1, 5);
    `CHK("busy", 1'b1, busy)
    @(negedge clk);
    `CHK("stimulus", 1'b1, stim)
    wait_for(busy, 1'b0, 300);
    // each phase holds its full time, tick skew included
    `CHK("test length", 1'b1, n >= 2*(tr+td)*CPT)
    `CHK("no fault", 1'b0, flt)
  endtask
  task automatic t_refuse(input sst_sens_t ty, input logic nm);
    sensor_type = ty;
    normal_mode = nm;
    depart();
    wait_for(stim, 1'b1, 8);
    `CHK("stimulus refused", 1'b0, stim)
    normal_mode = 1;
  endtask
  task automatic t_timeout();
    sensor_type = SST_SENS_EDGE;
    dead = 1;
    tmo = 16'h0005;
    depart();
    wait_for(busy, 1'b1, 5);
    wait_for(busy, 1'b0, 300);
    // the ms enable may fall up to one ms early against the start
    `CHK("test limit", 1'b1, n >= (2*5-1)*CPT && n <= 2*5*CPT + 2)
    `CHK("fault set", 1'b1, flt)
    @(negedge clk);
    `CHK("fault code", 8'h08, code)
    repeat (50) @(negedge clk);
    `CHK("fault held", 1'b1, flt)
    fault_ack = 1;
    @(negedge clk);
    fault_ack = 0;
    @(negedge clk);
    `CHK("fault cleared", 1'b0, flt)
    `CHK("code cleared", 8'h00, code)
    dead = 0;
    tmo = 16'h0064;
  endtask
  // obstacle from the tested sensor or from the light barrier
  task automatic t_react(input sst_sens_t ty, input logic bar);
    sensor_type = ty;
    constant_speed = ~bar; // barrier run travels off constant speed
    if (bar) light_barrier_input_b = 0;
    else obstacle = 1;
    wait_for(cur_red, 1'b1, 1000);
    `CHK("reaction", 1'b1, n >= 70*CPT && n <= 90*CPT)
    `CHK("reverse", ~bar, rev)
    @(negedge clk);
    `CHK("reverse pulse", 1'b0, rev)
    obstacle = 0;
    light_barrier_input_b = 1;
    constant_speed = 0;
    wait_for(cur_red, 1'b0, 5);
    `CHK("reduce released", 1'b0, cur_red)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1;
    normal_mode = 1;
    @(negedge clk);
    t_pass();
    t_refuse(SST_SENS_NONE, 1'b1);
    t_refuse(SST_SENS_RSVD, 1'b1);
    t_refuse(SST_SENS_CURTAIN, 1'b0);
    t_timeout();
    t_react(SST_SENS_CURTAIN, 1'b0);
    t_react(SST_SENS_EDGE, 1'b0);
    t_react(SST_SENS_CURTAIN, 1'b1);
    end_of_test();
  end
  // all scenarios need about 2700 cycles
  initial begin
    #200us;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
